// ===== rtl/rsc_pkg.sv
// Shared constants for the render statistics counter block.
package rsc_pkg;
  // Counter geometry.
  localparam int CNT_W = 24;
  localparam int CNT_N = 7;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  // Counter slots inside the counter bank.
  localparam int CNT_PIX_IN = 0;
  localparam int CNT_CHROMA = 1;
  localparam int CNT_DEPTH = 2;
  localparam int CNT_ALPHA = 3;
  localparam int CNT_STENCIL = 4;
  localparam int CNT_PIX_OUT = 5;
  localparam int CNT_TRI = 6;
  // Register indices on the register port.
  typedef logic [ADDR_W-1:0] rsc_idx_t;
  localparam rsc_idx_t REG_PIX_IN = 4'h0;
  localparam rsc_idx_t REG_CHROMA = 4'h1;
  localparam rsc_idx_t REG_DEPTH = 4'h2;
  localparam rsc_idx_t REG_ALPHA = 4'h3;
  localparam rsc_idx_t REG_STENCIL = 4'h4;
  localparam rsc_idx_t REG_PIX_OUT = 4'h5;
  localparam rsc_idx_t REG_HIST = 4'h6;
  localparam rsc_idx_t REG_TRI = 4'h7;
  localparam rsc_idx_t REG_NOP = 4'h8;
  localparam rsc_idx_t REG_SWAP_PEND = 4'h9;
  // Field positions of the no-operation command.
  localparam int NOP_CLR_PIX_BIT = 0;
  localparam int NOP_CLR_TRI_BIT = 1;
  // Swap history layout and reset values.
  localparam int HIST_NIB = 4;
  localparam int HIST_ENTRIES = 8;
  localparam logic [HIST_NIB-1:0] VSYNC_SAT = 4'hf;
  localparam logic [DATA_W-1:0] HIST_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_RESET = 24'h00_0000;
  // Width of the pending-swap count.
  localparam int SWAP_PEND_W = 3;
endpackage : rsc_pkg

// ===== rtl/rsc_cnt_if.sv
// Carrier between the control logic and the counter bank.
`timescale 1ns/10ps
`default_nettype none
interface rsc_cnt_if #(
  parameter int N = 7,
  parameter int W = 24
);
  logic [N-1:0] inc;
  logic [N-1:0] clr;
  logic [W-1:0] val [N];
  modport ctrl (output inc, output clr, input val);
  modport bank (input inc, input clr, output val);
endinterface : rsc_cnt_if
`default_nettype wire

// ===== rtl/rsc_cnt_bank.sv
// Bank of wrapping event counters with synchronous clear.
`timescale 1ns/10ps
`default_nettype none
module rsc_cnt_bank #(
  parameter int N = 7,
  parameter int W = 24
) (
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  rsc_cnt_if.bank   cnt
);
  import rsc_pkg::*;

  // wrap at width
  // Each counter wraps at its width; clear beats a same-cycle increment.
  for (genvar i = 0; i < N; i++)
  begin : g_cnt
    logic [W-1:0] count;
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
      if (!reset_n_in)
        count <= W'(CNT_RESET);
      else if (cnt.clr[i])
        count <= W'(CNT_RESET);
      else if (cnt.inc[i])
        count <= count + 1'b1;
    end
    assign cnt.val[i] = count;
  end
endmodule : rsc_cnt_bank
`default_nettype wire

// ===== rtl/rsc_swap_hist.sv
// Vertical sync counter and swap history shift register.
`timescale 1ns/10ps
`default_nettype none
module rsc_swap_hist (
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_n_in,
  input  wire logic                  vsync_in,
  input  wire logic                  swap_done_in,
  output logic [rsc_pkg::DATA_W-1:0] hist_out
);
  import rsc_pkg::*;

  logic [HIST_NIB-1:0] vsync_cnt;
  logic [HIST_NIB-1:0] next_vsync_cnt;
  logic                vsync_full;

  // Saturating count; a swap restarts it, counting a coincident vsync.
  assign vsync_full = (vsync_cnt == VSYNC_SAT);
  assign next_vsync_cnt = swap_done_in ? {{(HIST_NIB-1){1'b0}}, vsync_in}
                        : (vsync_in && !vsync_full) ? vsync_cnt + 1'b1
                        : vsync_cnt;

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      vsync_cnt <= '0;
    else
      vsync_cnt <= next_vsync_cnt;
  end

  // eight nibble entries
  // Older entries move up one nibble; the newest lands in the low nibble.
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      hist_out <= HIST_RESET;
    else if (swap_done_in)
      hist_out <= {hist_out[DATA_W-HIST_NIB-1:0], vsync_cnt};
  end
endmodule : rsc_swap_hist
`default_nettype wire

// ===== rtl/rsc_top.sv
// Render statistics counters, swap history and pending-swap count.
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - Count every pixel the triangle walker visits, drawn or not.
// - Pixel and test-failure counters reset to zero and clear on a one in no-op bit 0.
// - Count pixels discarded because their colour matches the key colour.
// - Count pixels discarded by a failing depth comparison.
// - Count pixels discarded by the alpha comparison or by alpha masking.
// - Count stencil-test discards, which only happen at 32 bits per pixel.
// - Count pixels actually written to a colour buffer by any rendering path.
// - The colour write mask does not stop a pixel from counting as drawn.
// - Count triangles walked, but not those removed by backface culling.
// - The triangle counter resets to zero and clears on a one in no-op bit 1.
// - A direct write of the swap-pending register bumps the pending-swap count at once, unless a swap finishes in that cycle or the count is full.
// - A finished swap shifts the history up a nibble and loads the saturated vsync count.
// - The history holds eight entries, newest in bits 3:0, oldest in bits 31:28.
module rsc_top (
  input  wire logic                       sys_clk_in,
  input  wire logic                       reset_n_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  input  wire rsc_pkg::rsc_idx_t          reg_addr_in,
  input  wire logic [rsc_pkg::DATA_W-1:0] reg_wdata_in,
  output logic [rsc_pkg::DATA_W-1:0]      reg_rdata_out,
  output logic                            reg_rvalid_out,
  input  wire logic                       pix_visit_in,
  input  wire logic                       chroma_fail_in,
  input  wire logic                       depth_fail_in,
  input  wire logic                       alpha_fail_in,
  input  wire logic                       alpha_mask_fail_in,
  input  wire logic                       stencil_fail_in,
  input  wire logic                       render_32bpp_in,
  input  wire logic                       pix_written_in,
  input  wire logic                       tri_walked_in,
  input  wire logic                       tri_culled_in,
  input  wire logic                       vsync_in,
  input  wire logic                       swap_done_in,
  output logic [rsc_pkg::SWAP_PEND_W-1:0] swap_pend_count_out
);
  import rsc_pkg::*;

  // Address decode shared by every write strobe.
  function automatic logic wr_hit(input logic wr, input rsc_idx_t addr,
                                  input rsc_idx_t idx);
    return wr && (addr == idx);
  endfunction : wr_hit

  rsc_cnt_if #(.N(CNT_N), .W(CNT_W)) cnt ();

  logic [DATA_W-1:0]      hist;
  logic [DATA_W-1:0]      next_rdata;
  logic [SWAP_PEND_W-1:0] next_swap_pend;
  logic [CNT_W-1:0]       pix_in_cnt;
  logic [CNT_W-1:0]       chroma_cnt;
  logic [CNT_W-1:0]       depth_cnt;
  logic [CNT_W-1:0]       alpha_cnt;
  logic [CNT_W-1:0]       stencil_cnt;
  logic [CNT_W-1:0]       pix_out_cnt;
  logic [CNT_W-1:0]       tri_cnt;
  wire logic              nop_wr;
  wire logic              swap_pend_wr;
  wire logic              clr_pix;
  wire logic              clr_tri;
  wire logic              pend_full;
  wire logic              pend_empty;

  // Write strobes decoded from the register port.
  assign nop_wr = wr_hit(reg_wr_in, reg_addr_in, REG_NOP);
  assign swap_pend_wr = wr_hit(reg_wr_in, reg_addr_in, REG_SWAP_PEND);
  assign clr_pix = nop_wr && reg_wdata_in[NOP_CLR_PIX_BIT];
  assign clr_tri = nop_wr && reg_wdata_in[NOP_CLR_TRI_BIT];

  // Clear strobes for the bank; the pixel group shares one strobe.
  assign cnt.clr[CNT_PIX_IN] = clr_pix;
  assign cnt.clr[CNT_CHROMA] = clr_pix;
  assign cnt.clr[CNT_DEPTH] = clr_pix;
  assign cnt.clr[CNT_ALPHA] = clr_pix;
  assign cnt.clr[CNT_STENCIL] = clr_pix;
  assign cnt.clr[CNT_PIX_OUT] = clr_pix;
  assign cnt.clr[CNT_TRI] = clr_tri;

  // Event mapping onto the counter bank.
  // every visited pixel
  assign cnt.inc[CNT_PIX_IN] = pix_visit_in;
  assign cnt.inc[CNT_CHROMA] = chroma_fail_in;
  assign cnt.inc[CNT_DEPTH] = depth_fail_in;
  assign cnt.inc[CNT_ALPHA] = alpha_fail_in || alpha_mask_fail_in;
  assign cnt.inc[CNT_STENCIL] = stencil_fail_in && render_32bpp_in;
  assign cnt.inc[CNT_PIX_OUT] = pix_written_in;
  assign cnt.inc[CNT_TRI] = tri_walked_in && !tri_culled_in;

  rsc_cnt_bank #(
    .N (CNT_N),
    .W (CNT_W)
  ) u_bank (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .cnt        (cnt)
  );

  rsc_swap_hist u_hist (
    .sys_clk_in   (sys_clk_in),
    .reset_n_in   (reset_n_in),
    .vsync_in     (vsync_in),
    .swap_done_in (swap_done_in),
    .hist_out     (hist)
  );

  // Named taps of the bank outputs for the read mux and checks.
  assign pix_in_cnt = cnt.val[CNT_PIX_IN];
  assign chroma_cnt = cnt.val[CNT_CHROMA];
  assign depth_cnt = cnt.val[CNT_DEPTH];
  assign alpha_cnt = cnt.val[CNT_ALPHA];
  assign stencil_cnt = cnt.val[CNT_STENCIL];
  assign pix_out_cnt = cnt.val[CNT_PIX_OUT];
  assign tri_cnt = cnt.val[CNT_TRI];

  // pending-swap count
  // A write adds one and a finished swap takes one; both together cancel.
  // The count saturates rather than wrapping so a runaway writer cannot
  // make the status look idle.
  assign pend_full = &swap_pend_count_out;
  assign pend_empty = ~|swap_pend_count_out;
  assign next_swap_pend =
    (swap_pend_wr && !swap_done_in && !pend_full) ? swap_pend_count_out + 1'b1 :
    (!swap_pend_wr && swap_done_in && !pend_empty) ? swap_pend_count_out - 1'b1 :
    swap_pend_count_out;

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      swap_pend_count_out <= '0;
    else
      swap_pend_count_out <= next_swap_pend;
  end

  // zero upper byte on counter reads
  // Read mux; write-only and unmapped indices read as zero.
  always_comb
  begin
    case (reg_addr_in)
      REG_PIX_IN:  next_rdata = {{(DATA_W-CNT_W){1'b0}}, pix_in_cnt};
      REG_CHROMA:  next_rdata = {{(DATA_W-CNT_W){1'b0}}, chroma_cnt};
      REG_DEPTH:   next_rdata = {{(DATA_W-CNT_W){1'b0}}, depth_cnt};
      REG_ALPHA:   next_rdata = {{(DATA_W-CNT_W){1'b0}}, alpha_cnt};
      REG_STENCIL: next_rdata = {{(DATA_W-CNT_W){1'b0}}, stencil_cnt};
      REG_PIX_OUT: next_rdata = {{(DATA_W-CNT_W){1'b0}}, pix_out_cnt};
      REG_HIST:    next_rdata = hist;
      REG_TRI:     next_rdata = {{(DATA_W-CNT_W){1'b0}}, tri_cnt};
      default:     next_rdata = '0;
    endcase
  end

  // Read data is registered; it holds until the next read.
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      reg_rdata_out <= '0;
      reg_rvalid_out <= 1'b0;
    end
    else
    begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in)
        reg_rdata_out <= next_rdata;
    end
  end

  // Checks on the counting and history behaviour.
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  AST_PIX_IN_INC: assert property (
    pix_visit_in && !clr_pix |=> pix_in_cnt == $past(pix_in_cnt) + 24'h1)
    else $error("Processed pixel count missed a visited pixel.");

  AST_PIX_CLEAR: assert property (
    clr_pix |=> pix_in_cnt == '0 && chroma_cnt == '0 && depth_cnt == '0
      && alpha_cnt == '0 && stencil_cnt == '0 && pix_out_cnt == '0)
    else $error("Pixel counters did not clear on no-op bit 0.");

  AST_CHROMA_HOLD: assert property (
    !chroma_fail_in && !clr_pix |=> $stable(chroma_cnt))
    else $error("Chroma reject count moved without an event.");

  AST_DEPTH_INC: assert property (
    depth_fail_in && !clr_pix |=> depth_cnt == $past(depth_cnt) + 24'h1)
    else $error("Depth reject count missed a failure.");

  AST_ALPHA_MASK_INC: assert property (
    alpha_mask_fail_in && !clr_pix |=> alpha_cnt == $past(alpha_cnt) + 24'h1)
    else $error("Alpha reject count missed an alpha mask discard.");

  AST_STENCIL_16BPP: assert property (
    !render_32bpp_in && !clr_pix |=> $stable(stencil_cnt))
    else $error("Stencil count moved outside 32 bpp rendering.");

  AST_PIX_OUT_INC: assert property (
    pix_written_in && !clr_pix |=> pix_out_cnt == $past(pix_out_cnt) + 24'h1)
    else $error("Drawn pixel count missed a written pixel.");

  AST_TRI_CULLED: assert property (
    tri_culled_in && !clr_tri |=> $stable(tri_cnt))
    else $error("Triangle count moved on a culled triangle.");

  AST_TRI_CLEAR: assert property (
    clr_tri && !clr_pix && !pix_visit_in |=> tri_cnt == '0 && $stable(pix_in_cnt))
    else $error("Triangle clear misbehaved or touched pixel counters.");

  AST_SWAP_PEND_INC: assert property (
    swap_pend_wr && !swap_done_in && !pend_full
      |=> swap_pend_count_out == $past(swap_pend_count_out) + 3'h1)
    else $error("Pending-swap count did not rise on a write.");

  AST_HIST_SHIFT: assert property (
    swap_done_in |=> hist[31:4] == $past(hist[27:0]))
    else $error("Swap history did not shift on a finished swap.");

  AST_HIST_HOLD: assert property (
    !swap_done_in |=> $stable(hist))
    else $error("Swap history changed without a swap.");

  AST_READ_UPPER: assert property (
    reg_rd_in && reg_addr_in != REG_HIST |=> reg_rvalid_out && reg_rdata_out[31:24] == 8'h00)
    else $error("Counter read returned a non-zero upper byte.");

  // Increment checks for the remaining counters.
  AST_CHROMA_INC: assert property (
    chroma_fail_in && !clr_pix |=> chroma_cnt == $past(chroma_cnt) + 24'h1)
    else $error("Chroma reject count missed a key colour match.");

  AST_ALPHA_INC: assert property (
    alpha_fail_in && !clr_pix |=> alpha_cnt == $past(alpha_cnt) + 24'h1)
    else $error("Alpha reject count missed an alpha compare discard.");

  AST_STENCIL_INC: assert property (
    stencil_fail_in && render_32bpp_in && !clr_pix |=> stencil_cnt == $past(stencil_cnt) + 24'h1)
    else $error("Stencil reject count missed a failure at 32 bpp.");

  AST_TRI_INC: assert property (
    tri_walked_in && !tri_culled_in && !clr_tri |=> tri_cnt == $past(tri_cnt) + 24'h1)
    else $error("Triangle count missed a walked triangle.");

  // Hold checks: a counter without an event or a clear must not move.
  AST_PIX_IN_HOLD: assert property (
    !pix_visit_in && !clr_pix |=> $stable(pix_in_cnt))
    else $error("Processed pixel count moved without a visit.");

  AST_DEPTH_HOLD: assert property (
    !depth_fail_in && !clr_pix |=> $stable(depth_cnt))
    else $error("Depth reject count moved without a failure.");

  AST_ALPHA_HOLD: assert property (
    !alpha_fail_in && !alpha_mask_fail_in && !clr_pix |=> $stable(alpha_cnt))
    else $error("Alpha reject count moved without a discard.");

  AST_STENCIL_HOLD: assert property (
    !stencil_fail_in && !clr_pix |=> $stable(stencil_cnt))
    else $error("Stencil reject count moved without a failure.");

  AST_PIX_OUT_HOLD: assert property (
    !pix_written_in && !clr_pix |=> $stable(pix_out_cnt))
    else $error("Drawn pixel count moved without a written pixel.");

  AST_TRI_HOLD: assert property (
    !tri_walked_in && !clr_tri |=> $stable(tri_cnt))
    else $error("Triangle count moved without a walked triangle.");

  // Pending-swap bookkeeping around finished swaps and saturation.
  AST_SWAP_PEND_DEC: assert property (
    swap_done_in && !swap_pend_wr && !pend_empty
      |=> swap_pend_count_out == $past(swap_pend_count_out) - 3'h1)
    else $error("Pending-swap count did not fall on a finished swap.");

  AST_SWAP_PEND_CANCEL: assert property (
    swap_done_in && swap_pend_wr |=> $stable(swap_pend_count_out))
    else $error("Pending-swap count moved when write and swap coincided.");

  AST_SWAP_PEND_SAT: assert property (
    pend_full && swap_pend_wr && !swap_done_in |=> pend_full)
    else $error("Pending-swap count wrapped instead of saturating.");

  // Main scenarios worth seeing in simulation.
  COV_PIX_WRAP: cover property (
    pix_visit_in && !clr_pix && pix_in_cnt == 24'hff_ffff ##1 pix_in_cnt == '0);
  COV_HIST_FULL: cover property (
    swap_done_in && hist[27:24] != 4'h0 ##1 hist[31:28] != 4'h0);
  COV_PEND_CANCEL: cover property (swap_pend_wr && swap_done_in);
  COV_CLR_AND_EVENT: cover property (clr_pix && pix_visit_in);
endmodule : rsc_top
`default_nettype wire

// ===== verif/rsc_evt_src.sv
// Event source standing in for the pixel pipeline and triangle walker.
`timescale 1ns/10ps
`default_nettype none
module rsc_evt_src (
  input  wire logic        sys_clk_in,
  output logic      [11:0] evt_out
);
  // Event lines idle low, as a pipeline with no traffic leaves them.
  initial evt_out = 12'h000;

  // Bit 6 qualifies stencil events.
  // Holds a pattern for n cycles, then drops every line for one cycle.
  task automatic pulse(input logic [11:0] pat, input int n);
    repeat (n)
    begin
      @(negedge sys_clk_in);
      evt_out = pat;
    end
    @(negedge sys_clk_in);
    evt_out = 12'h000;
  endtask : pulse
endmodule : rsc_evt_src
`default_nettype wire

// ===== verif/rsc_top_tb.sv
// Self-checking testbench for the render statistics counters.
`timescale 1ns/10ps
`default_nettype none
module rsc_top_tb;
  import rsc_pkg::*;
  logic                   sys_clk_in;
  logic                   reset_n_in;
  logic                   reg_wr;
  logic                   reg_rd;
  rsc_idx_t               reg_addr;
  logic [DATA_W-1:0]      reg_wdata;
  logic [DATA_W-1:0]      rdata;
  logic                   rvalid;
  logic [SWAP_PEND_W-1:0] pend;
  logic [11:0]            evt;
  logic [DATA_W-1:0]      exp_r [8];
  int                     error_cnt;
  int                     num_checks;
  int                     cycles;

  // Event bits: pixel, chroma, depth, alpha, mask, stencil, 32bpp,
  // written, triangle, culled, vsync, swap done.
  rsc_top i_rsc_top (
    .sys_clk_in         (sys_clk_in),
    .reset_n_in         (reset_n_in),
    .reg_wr_in          (reg_wr),
    .reg_rd_in          (reg_rd),
    .reg_addr_in        (reg_addr),
    .reg_wdata_in       (reg_wdata),
    .reg_rdata_out      (rdata),
    .reg_rvalid_out     (rvalid),
    .pix_visit_in       (evt[0]),
    .chroma_fail_in     (evt[1]),
    .depth_fail_in      (evt[2]),
    .alpha_fail_in      (evt[3]),
    .alpha_mask_fail_in (evt[4]),
    .stencil_fail_in    (evt[5]),
    .render_32bpp_in    (evt[6]),
    .pix_written_in     (evt[7]),
    .tri_walked_in      (evt[8]),
    .tri_culled_in      (evt[9]),
    .vsync_in           (evt[10]),
    .swap_done_in       (evt[11]),
    .swap_pend_count_out(pend)
  );

  rsc_evt_src i_rsc_evt_src (
    .sys_clk_in(sys_clk_in),
    .evt_out   (evt)
  );

  // 200 MHz core clock.
  initial
  begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  // The whole run needs well under a thousand cycles, so a hang is cut short.
  always @(posedge sys_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task report_and_stop;
    $display("errors %0d checks %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  task chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Read strobe for one cycle; the answer is looked at in the cycle it stands.
  task rd(input rsc_idx_t a, input logic [DATA_W-1:0] e);
    @(negedge sys_clk_in);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk_in);
    reg_rd = 1'b0;
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, e);
  endtask : rd

  task wr(input rsc_idx_t a, input logic [DATA_W-1:0] d);
    @(negedge sys_clk_in);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk_in);
    reg_wr = 1'b0;
  endtask : wr

  task rd_all;
    for (int i = 0; i < 8; i++)
      rd(rsc_idx_t'(i), exp_r[i]);
  endtask : rd_all

  // Main sequence: reset values, event counting, clears, history, pending.
  initial
  begin
    reset_n_in = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    error_cnt = 0;
    num_checks = 0;
    cycles = 0;
    repeat (2) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    for (int i = 0; i < 10; i++)
      rd(rsc_idx_t'(i), 32'h0);
    rd(4'hf, 32'h0);
    i_rsc_evt_src.pulse(12'h18f, 3);
    i_rsc_evt_src.pulse(12'h018, 2);
    i_rsc_evt_src.pulse(12'h010, 1);
    i_rsc_evt_src.pulse(12'h020, 2);
    i_rsc_evt_src.pulse(12'h060, 3);
    i_rsc_evt_src.pulse(12'h300, 2);
    wr(REG_PIX_IN, 32'hffff_ffff);
    exp_r = '{32'h3, 32'h3, 32'h3, 32'h6, 32'h3, 32'h3, 32'h0, 32'h3};
    rd_all();
    wr(REG_NOP, 32'h1);
    exp_r = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h3};
    rd_all();
    wr(REG_NOP, 32'h2);
    rd(REG_TRI, 32'h0);
    // A clear in the same cycle as events must win, so the events are lost.
    fork
      wr(REG_NOP, 32'h3);
      i_rsc_evt_src.pulse(12'h181, 1);
    join
    rd(REG_PIX_IN, 32'h0);
    rd(REG_PIX_OUT, 32'h0);
    rd(REG_TRI, 32'h0);
    i_rsc_evt_src.pulse(12'h400, 2);
    i_rsc_evt_src.pulse(12'h800, 1);
    i_rsc_evt_src.pulse(12'h400, 20);
    i_rsc_evt_src.pulse(12'h800, 1);
    i_rsc_evt_src.pulse(12'h800, 1);
    rd(REG_HIST, 32'h0000_02f0);
    repeat (6)
    begin
      i_rsc_evt_src.pulse(12'h400, 1);
      i_rsc_evt_src.pulse(12'h800, 1);
    end
    rd(REG_HIST, 32'hf011_1111);
    repeat (3) wr(REG_SWAP_PEND, 32'h0);
    chk({29'h0, pend}, 32'h3);
    // A finished swap takes one off; a write in the same cycle cancels it.
    i_rsc_evt_src.pulse(12'h800, 1);
    chk({29'h0, pend}, 32'h2);
    fork
      wr(REG_SWAP_PEND, 32'h0);
      i_rsc_evt_src.pulse(12'h800, 1);
    join
    chk({29'h0, pend}, 32'h2);
    // Six more writes run past the top, so the count must stop at seven.
    repeat (6) wr(REG_SWAP_PEND, 32'h0);
    chk({29'h0, pend}, 32'h7);
    report_and_stop();
  end
endmodule : rsc_top_tb
`default_nettype wire
